// File: design/bfcsm_pkg.sv
package bfcsm_pkg;
  // 16 Mbit per select, addressed as 16-bit words: 1M words, 20 bits
  localparam int          WORD_AW      = 20;
  localparam int          SEL_N        = 3;
  localparam int          UNI_AW       = 22;
  // Unified map: boot region first, then select two, then select zero
  localparam logic [1:0]  REG_BOOT     = 2'h0;
  localparam logic [1:0]  REG_TWO      = 2'h1;
  localparam logic [1:0]  REG_ZERO     = 2'h2;
  localparam int          IDX_ZERO     = 0;
  localparam int          IDX_BOOT     = 1;
  localparam int          IDX_TWO      = 2;
  // Reserved top area, in words; 1 Mbit = 64K words
  localparam logic [WORD_AW-1:0] RSV_MAX_WORDS = 20'h1_0000;
  localparam logic [WORD_AW-1:0] PROBE_ADDR    = 20'h0_0000;
  localparam logic [WORD_AW-1:0] WORD_ONE      = 20'h0_0001;
  localparam logic [15:0] BLANK_WORD   = 16'hFFFF;

  typedef enum logic [1:0] {
    BFCSM_MODE_VIDEO  = 2'h0,
    BFCSM_MODE_VPAT   = 2'h1,
    BFCSM_MODE_STORED = 2'h2,
    BFCSM_MODE_OTF    = 2'h3
  } bfcsm_mode_e;

  typedef enum logic [5:0] {
    BFCSM_ST_PROBE  = 6'b00_0001,
    BFCSM_ST_WAIT   = 6'b00_0010,
    BFCSM_ST_CHECK  = 6'b00_0100,
    BFCSM_ST_HALT   = 6'b00_1000,
    BFCSM_ST_IDLE   = 6'b01_0000,
    BFCSM_ST_LOAD   = 6'b10_0000
  } bfcsm_state_e;

  typedef struct packed {
    logic [UNI_AW-1:0] addr;
    logic              rd;
  } bfcsm_req_s;

  typedef struct packed {
    logic [SEL_N-1:0]   sel_n;
    logic [WORD_AW-1:0] addr;
    logic               oe_n;
  } bfcsm_flash_s;
endpackage : bfcsm_pkg

// File: design/bfcsm_top.sv
// Function
// - Three chip-selects, each at most 16 Mbit, 48 Mbit total.
// - Firmware fetched only from boot select one after power-up.
// - At power-up probe each chip-select in turn for responding memory.
// - No memory on boot select: startup never completes.
// - Stored-pattern mode copies needed images from flash at sequence start.
// - Other modes take images from video or host, never from flash.
// - Reserved top area, default and at most 1 Mbit, may shrink.
`timescale 1ns/1ps
`default_nettype none
module bfcsm_top
  import bfcsm_pkg::*;
(
  input  wire logic                       clk,
  input  wire logic                       rstn,
  input  wire bfcsm_pkg::bfcsm_mode_e     mode,
  input  wire logic [bfcsm_pkg::WORD_AW-1:0] rsv_words,
  input  wire logic                       seq_start,
  input  wire logic [bfcsm_pkg::UNI_AW-1:0] load_first,
  input  wire logic [bfcsm_pkg::UNI_AW-1:0] load_last,
  input  wire logic                       fw_rd,
  input  wire logic [bfcsm_pkg::WORD_AW-1:0] fw_addr,
  input  wire logic [15:0]                flash_dq,
  output logic [bfcsm_pkg::SEL_N-1:0]     flash_sel_n,
  output logic [bfcsm_pkg::WORD_AW-1:0]   flash_addr,
  output logic                            flash_oe_n,
  output logic [bfcsm_pkg::SEL_N-1:0]     present,
  output logic                            boot_ok,
  output logic                            boot_fail,
  output logic                            load_busy,
  output logic                            img_valid,
  output logic [15:0]                     img_data,
  output logic [bfcsm_pkg::WORD_AW-1:0]   rsv_size
);
  import bfcsm_pkg::*;

  bfcsm_state_e              st_r, st_nxt;
  logic [1:0]                idx_r, idx_nxt;
  logic [SEL_N-1:0]          pres_r, pres_nxt;
  bfcsm_req_s                req_r, req_nxt;
  bfcsm_flash_s              fl_r, fl_nxt;
  logic                      vld_r, vld_nxt;
  logic [15:0]               dat_r, dat_nxt;
  logic [WORD_AW-1:0]        rsv_r, rsv_nxt;
  logic                      rd_d_r, rd_d_nxt;
  logic [1:0]                region;
  logic [SEL_N-1:0]          dec_n;
  logic [1:0]                probe_sel;
  logic                      boot_ok_r, boot_ok_nxt;
  logic                      boot_fail_r, boot_fail_nxt;
  logic                      busy_r, busy_nxt;

  // Probe step to select index; boot first since firmware lives there
  always_comb begin
    probe_sel = 2'(IDX_BOOT);
    case (idx_r)
      2'h0:    probe_sel = 2'(IDX_BOOT);
      2'h1:    probe_sel = 2'(IDX_TWO);
      2'h2:    probe_sel = 2'(IDX_ZERO);
      default: probe_sel = 2'(IDX_BOOT);
    endcase
  end

  // One-hot low select from upper unified bits
  assign region = req_r.addr[UNI_AW-1 -: 2];
  always_comb begin
    dec_n = '1;
    case (region)
      REG_BOOT: dec_n[IDX_BOOT] = 1'b0;
      REG_TWO:  dec_n[IDX_TWO]  = 1'b0;
      REG_ZERO: dec_n[IDX_ZERO] = 1'b0;
      default:  dec_n = '1;
    endcase
  end

  always_comb begin
    st_nxt   = st_r;
    idx_nxt  = idx_r;
    pres_nxt = pres_r;
    req_nxt  = req_r;
    fl_nxt   = '{sel_n: '1, addr: fl_r.addr, oe_n: 1'b1};
    vld_nxt  = 1'b0;
    dat_nxt  = dat_r;
    rd_d_nxt = 1'b0;
    // Limited to 1 Mbit even if firmware asks for more
    rsv_nxt  = (rsv_words > RSV_MAX_WORDS) ? RSV_MAX_WORDS : rsv_words;
    case (st_r)
      BFCSM_ST_PROBE: begin
        fl_nxt.sel_n = '1;
        fl_nxt.sel_n[probe_sel] = 1'b0;
        fl_nxt.addr  = PROBE_ADDR;
        fl_nxt.oe_n  = 1'b0;
        st_nxt       = BFCSM_ST_WAIT;
      end
      BFCSM_ST_WAIT: begin
        // Select held so the word is taken while the part still drives it
        fl_nxt = fl_r;
        st_nxt = BFCSM_ST_CHECK;
      end
      BFCSM_ST_CHECK: begin
        // Undriven data bus floats high: treat all-ones as absent
        pres_nxt[probe_sel] = (flash_dq != BLANK_WORD);
        if (idx_r == 2'(SEL_N - 1)) begin
          if (pres_nxt[IDX_BOOT]) begin
            st_nxt = BFCSM_ST_IDLE;
          end else begin
            st_nxt = BFCSM_ST_HALT;
          end
        end else begin
          idx_nxt = idx_r + 2'h1;
          st_nxt  = BFCSM_ST_PROBE;
        end
      end
      BFCSM_ST_HALT: begin
        st_nxt = BFCSM_ST_HALT;
      end
      BFCSM_ST_IDLE: begin
        if (fw_rd) begin
          fl_nxt.sel_n = '1;
          fl_nxt.sel_n[IDX_BOOT] = 1'b0;
          fl_nxt.addr  = fw_addr;
          fl_nxt.oe_n  = 1'b0;
          rd_d_nxt     = 1'b1;
        end else if (seq_start && mode == BFCSM_MODE_STORED) begin
          req_nxt.addr = load_first;
          req_nxt.rd   = 1'b1;
          st_nxt       = BFCSM_ST_LOAD;
        end
      end
      BFCSM_ST_LOAD: begin
        // Absent or unmapped regions are skipped rather than read as garbage
        if ((dec_n != '1) && pres_r[region == REG_BOOT ? IDX_BOOT : region == REG_TWO ? IDX_TWO : IDX_ZERO]) begin
          fl_nxt.sel_n = dec_n;
          fl_nxt.addr  = req_r.addr[WORD_AW-1:0];
          fl_nxt.oe_n  = 1'b0;
          rd_d_nxt     = 1'b1;
        end
        if (req_r.addr == load_last) begin
          req_nxt.rd = 1'b0;
          st_nxt     = BFCSM_ST_IDLE;
        end else begin
          req_nxt.addr = req_r.addr + UNI_AW'(1);
        end
      end
      default: st_nxt = BFCSM_ST_HALT;
    endcase
    if (rd_d_r) begin
      vld_nxt = 1'b1;
      dat_nxt = flash_dq;
    end
    boot_ok_nxt   = (st_nxt == BFCSM_ST_IDLE) || (st_nxt == BFCSM_ST_LOAD);
    boot_fail_nxt = (st_nxt == BFCSM_ST_HALT);
    busy_nxt      = (st_nxt == BFCSM_ST_LOAD);
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_r   <= BFCSM_ST_PROBE;
      idx_r  <= 2'h0;
      pres_r <= '0;
      req_r  <= '0;
      fl_r   <= '{sel_n: '1, addr: '0, oe_n: 1'b1};
      vld_r  <= 1'b0;
      dat_r  <= '0;
      rsv_r  <= RSV_MAX_WORDS;
      rd_d_r <= 1'b0;
      boot_ok_r   <= 1'b0;
      boot_fail_r <= 1'b0;
      busy_r      <= 1'b0;
    end else begin
      st_r   <= st_nxt;
      idx_r  <= idx_nxt;
      pres_r <= pres_nxt;
      req_r  <= req_nxt;
      fl_r   <= fl_nxt;
      vld_r  <= vld_nxt;
      dat_r  <= dat_nxt;
      rsv_r  <= rsv_nxt;
      rd_d_r <= rd_d_nxt;
      boot_ok_r   <= boot_ok_nxt;
      boot_fail_r <= boot_fail_nxt;
      busy_r      <= busy_nxt;
    end
  end

  assign flash_sel_n = fl_r.sel_n;
  assign flash_addr  = fl_r.addr;
  assign flash_oe_n  = fl_r.oe_n;
  assign present     = pres_r;
  assign boot_ok     = boot_ok_r;
  assign boot_fail   = boot_fail_r;
  assign load_busy   = busy_r;
  assign img_valid   = vld_r;
  assign img_data    = dat_r;
  assign rsv_size    = rsv_r;

  a_one_select: assert property (@(posedge clk) disable iff (!rstn)
    $countones(~flash_sel_n) <= 1) else $error("More than one select low");
  a_fw_boot_only: assert property (@(posedge clk) disable iff (!rstn)
    (st_r == BFCSM_ST_IDLE && fw_rd) |=> (flash_sel_n == 3'b101)) else $error("Firmware read off boot select");
  a_fail_halts: assert property (@(posedge clk) disable iff (!rstn)
    boot_fail |=> boot_fail && !boot_ok) else $error("Startup left halt");
  a_no_load_other: assert property (@(posedge clk) disable iff (!rstn)
    (st_r == BFCSM_ST_IDLE && seq_start && !fw_rd && mode != BFCSM_MODE_STORED) |=> !load_busy)
    else $error("Flash load outside stored mode");
  a_load_starts: assert property (@(posedge clk) disable iff (!rstn)
    (st_r == BFCSM_ST_IDLE && seq_start && !fw_rd && mode == BFCSM_MODE_STORED) |=> load_busy)
    else $error("Stored load did not start");
  a_rsv_cap: assert property (@(posedge clk) disable iff (!rstn)
    rsv_size <= RSV_MAX_WORDS) else $error("Reserved area too large");
  a_probe_done: assert property (@(posedge clk) disable iff (!rstn)
    $rose(rstn) |-> ##[1:12] (boot_ok || boot_fail)) else $error("Probe did not finish");
  a_boot_needs: assert property (@(posedge clk) disable iff (!rstn)
    $rose(boot_ok) |-> present[IDX_BOOT]) else $error("Boot without boot memory");
endmodule : bfcsm_top
`default_nettype wire

// File: verif/bfcsm_flash_model.sv
`timescale 1ns/1ps
`default_nettype none
module bfcsm_flash_model
  import bfcsm_pkg::*;
(
  input  wire logic                          merged,
  input  wire logic [bfcsm_pkg::SEL_N-1:0]   pop,
  input  wire logic [bfcsm_pkg::SEL_N-1:0]   sel_n,
  input  wire logic [bfcsm_pkg::WORD_AW-1:0] addr,
  input  wire logic                          oe_n,
  output logic      [15:0]                   dq
);
  // Part description: uniform 64K-word sectors, each region on a sector boundary
  localparam int SECT_AW = 16;
  logic       dev_sel_n;
  logic [1:0] up;
  logic [5:0] sect;
  // Glue logic: one device select, inverted upper lines from the selects
  assign dev_sel_n = &sel_n;
  assign up        = {~sel_n[IDX_ZERO], ~sel_n[IDX_TWO]};
  assign sect      = {up, addr[WORD_AW-1:SECT_AW]};
  // One part per populated select, same density everywhere
  function automatic logic [15:0] word(input logic [2:0] s, input logic [19:0] a, input logic o, input logic [2:0] p);
    return (!o && s != 3'h7 && (~s & p) != 3'h0) ? {s, 1'b0, a[11:0]} : 16'hFFFF;
  endfunction : word
  // Deselected bus goes to the pull-up level at once
  always_comb begin
    if (merged) begin
      dq = (!oe_n && !dev_sel_n) ? {~sect[4], |sect[5:4], ~sect[5], 1'b0, addr[11:0]} : 16'hFFFF;
    end else begin
      dq = word(sel_n, addr, oe_n, pop);
    end
  end
endmodule : bfcsm_flash_model
`default_nettype wire

// File: verif/tb_bfcsm_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_bfcsm_top;
  import bfcsm_pkg::*;
  logic        clk = 0, rstn = 0, seq_start = 0, fw_rd = 0, oe_n, boot_ok, boot_fail, load_busy, img_valid;
  bfcsm_mode_e mode = BFCSM_MODE_VIDEO;
  logic [19:0] rsv_words = 20'h1_0000, fw_addr = 20'h0_0000, addr, rsv_size;
  logic [21:0] load_first = 22'h00_0000, load_last = 22'h00_0000;
  logic [2:0]  pop = 3'h7, sel_n, present;
  logic        merged = 0;
  logic [15:0] dq, img_data;
  int          err_total = 0, checks_done = 0;
  always #2.5 clk = ~clk;
  bfcsm_top dut (.clk(clk), .rstn(rstn), .mode(mode), .rsv_words(rsv_words), .seq_start(seq_start),
    .load_first(load_first), .load_last(load_last), .fw_rd(fw_rd), .fw_addr(fw_addr), .flash_dq(dq),
    .flash_sel_n(sel_n), .flash_addr(addr), .flash_oe_n(oe_n), .present(present), .boot_ok(boot_ok),
    .boot_fail(boot_fail), .load_busy(load_busy), .img_valid(img_valid), .img_data(img_data), .rsv_size(rsv_size));
  bfcsm_flash_model flash (.merged(merged), .pop(pop), .sel_n(sel_n), .addr(addr), .oe_n(oe_n), .dq(dq));
  task automatic chk(input string nm, input logic [21:0] got, input logic [21:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic end_of_test();
    if (err_total == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : end_of_test
  always @(negedge clk) if (rstn) chk("one_select", 22'($onehot0(~sel_n)), 22'h1);
  task automatic boot(input logic [2:0] p, input logic ok);
    int n;
    @(posedge clk);
    pop <= p;
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    #1 chk("rst_sel", 22'(sel_n), 22'h7);
    chk("rst_rsv", 22'(rsv_size), 22'h1_0000);
    @(posedge clk);
    rstn <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge clk);
      #1;
      if (boot_ok === 1'b1 || boot_fail === 1'b1) break;
    end
    if (n == 40) begin
      err_total++;
      end_of_test();
    end
    repeat (4) @(posedge clk);
    #1 chk("present", 22'(present), 22'(p));
    chk("boot_ok", 22'(boot_ok), 22'(ok));
    chk("boot_fail", 22'(boot_fail), 22'(!ok));
  endtask : boot
  task automatic fw_read(input logic [19:0] a, input logic v);
    int   n;
    logic got;
    got = 1'b0;
    @(posedge clk);
    fw_rd <= 1'b1;
    fw_addr <= a;
    @(posedge clk);
    fw_rd <= 1'b0;
    for (n = 0; n < 6; n++) begin
      #1;
      if (img_valid === 1'b1) begin
        got = 1'b1;
        chk("fw_data", 22'(img_data), 22'({3'b101, 1'b0, a[11:0]}));
      end
      @(posedge clk);
    end
    chk("fw_valid", 22'(got), 22'(v));
  endtask : fw_read
  task automatic load(input bfcsm_mode_e m, input logic [21:0] f, input logic [21:0] l, input logic [2:0] s, input int c);
    int n, k;
    k = 0;
    @(posedge clk);
    mode <= m;
    load_first <= f;
    load_last <= l;
    @(posedge clk);
    seq_start <= 1'b1;
    @(posedge clk);
    seq_start <= 1'b0;
    for (n = 0; n < 20; n++) begin
      #1;
      if (n == 0) chk("load_busy", 22'(load_busy), 22'(m == BFCSM_MODE_STORED));
      if (img_valid === 1'b1) begin
        chk("img_data", 22'(img_data), 22'({s, 1'b0, f[11:0] + 12'(k)}));
        k++;
      end
      @(posedge clk);
    end
    chk("img_count", 22'(k), 22'(c));
  endtask : load
  task automatic rsv(input logic [19:0] w, input logic [19:0] e);
    @(posedge clk);
    rsv_words <= w;
    repeat (3) @(posedge clk);
    #1 chk("rsv_size", 22'(rsv_size), 22'(e));
  endtask : rsv
  initial begin
    boot(3'h7, 1'b1);
    fw_read(20'h0_0123, 1'b1);
    fw_read(20'hF_FFFF, 1'b1);
    rsv(20'h0_8000, 20'h0_8000);
    rsv(20'hF_FFFF, 20'h1_0000);
    load(BFCSM_MODE_VIDEO, 22'h10_0005, 22'h10_0007, 3'b011, 0);
    load(BFCSM_MODE_VPAT, 22'h10_0005, 22'h10_0007, 3'b011, 0);
    load(BFCSM_MODE_OTF, 22'h10_0005, 22'h10_0007, 3'b011, 0);
    load(BFCSM_MODE_STORED, 22'h10_0005, 22'h10_0007, 3'b011, 3);
    load(BFCSM_MODE_STORED, 22'h20_0010, 22'h20_0011, 3'b110, 2);
    // Two parts sit on selects one and two
    boot(3'h6, 1'b1);
    load(BFCSM_MODE_STORED, 22'h20_0010, 22'h20_0011, 3'b110, 0);
    boot(3'h5, 1'b0);
    fw_read(20'h0_0001, 1'b0);
    // One part behind glue logic answers for all three selects
    @(posedge clk);
    merged <= 1'b1;
    boot(3'h7, 1'b1);
    load(BFCSM_MODE_STORED, 22'h20_0010, 22'h20_0011, 3'b110, 2);
    fw_read(20'h0_0042, 1'b1);
    end_of_test();
  end
endmodule : tb_bfcsm_top
`default_nettype wire
